// file: logic/ebl_loader.sv
// Board setup loader: serial EEPROM fetch at reset plus software access over AXI4-Lite
`timescale 1ns/1ps
`include "ebl_cfg.svh"

module ebl_loader #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [2:0] config_slot_pins_i,
  input wire logic eeprom_present_pin_i,
  output logic ee_cs_o,
  output logic ee_sk_o,
  output logic ee_di_o,
  input wire logic ee_do_i,
  output logic [15:0] config_word_o,
  output logic [15:0] base_word_o,
  output logic [47:0] station_addr_bytes_o,
  output logic loader_busy_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = old;
    if (s[0]) begin
      m[7:0] = d[7:0];
    end
    if (s[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction : merge16

  // Word command for one step of the current access
  function automatic ebl_pkg::ebl_cmd_t op_for(input ebl_pkg::ebl_core_t c);
    ebl_pkg::ebl_cmd_t k;
    logic [5:0] slot_base;
    slot_base = {1'b0, c.slot_s2, 2'b00};
    k.wr = 1'b0;
    k.addr = 6'h00;
    k.wdata = 16'h0000;
    unique case (c.mode)
      ebl_pkg::EBL_M_LOAD: begin
        if (c.step < 3'h3) begin
          k.addr = `EBL_EE_STA_ADDR + {4'h0, c.step[1:0]};
        end else begin
          k.addr = slot_base + {5'h00, c.step == 3'h4};
        end
      end
      ebl_pkg::EBL_M_STORE: begin
        k.wr = 1'b1;
        k.addr = slot_base + {5'h00, c.step[0]};
        k.wdata = c.step[0] ? c.base : c.cfg;
      end
      ebl_pkg::EBL_M_GP_RD: begin
        k.addr = c.ptr[5:0];
      end
      ebl_pkg::EBL_M_GP_WR: begin
        k.wr = 1'b1;
        k.addr = c.ptr[5:0];
        k.wdata = c.gp;
      end
    endcase
    return k;
  endfunction : op_for

  // Last step index of the access in progress
  function automatic logic [2:0] last_step(input ebl_pkg::ebl_core_t c);
    logic [2:0] l;
    l = 3'h0;
    if (c.mode == ebl_pkg::EBL_M_LOAD) begin
      l = (c.slot_s2 == `EBL_SLOT_DEFAULT) ? 3'h2 : 3'h4;
    end else if (c.mode == ebl_pkg::EBL_M_STORE) begin
      l = 3'h1;
    end
    return l;
  endfunction : last_step

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  ebl_pkg::ebl_core_t r_reg;
  ebl_pkg::ebl_core_t r_next;
  ebl_pkg::ebl_link_t l_reg;
  ebl_pkg::ebl_link_t l_next;
  logic busy;
  logic [7:0] waddr;
  logic [7:0] raddr;

  assign busy = (r_reg.state != ebl_pkg::EBL_C_IDLE);
  assign waddr = {r_reg.aw_addr[7:2], 2'b00};
  assign raddr = {s_axi_araddr_i[7:2], 2'b00};

  // Bus handshakes; one outstanding write and one read
  assign s_axi_awready_o = !r_reg.aw_full && !r_reg.bvalid;
  assign s_axi_wready_o = !r_reg.w_full && !r_reg.bvalid;
  assign s_axi_arready_o = !r_reg.rvalid;
  assign s_axi_bvalid_o = r_reg.bvalid;
  assign s_axi_bresp_o = r_reg.bresp;
  assign s_axi_rvalid_o = r_reg.rvalid;
  assign s_axi_rdata_o = r_reg.rdata;
  assign s_axi_rresp_o = r_reg.rresp;
  assign config_word_o = r_reg.cfg;
  assign base_word_o = r_reg.base;
  assign station_addr_bytes_o = {r_reg.sta2, r_reg.sta1, r_reg.sta0};
  assign loader_busy_o = busy;

  // Core next state: pin sync, sequencer, register file
  always_comb begin
    r_next = r_reg;
    r_next.slot_s1 = config_slot_pins_i;
    r_next.slot_s2 = r_reg.slot_s1;
    r_next.pres_s1 = eeprom_present_pin_i;
    r_next.pres_s2 = r_reg.pres_s1;
    r_next.ack_s1 = l_reg.ack_tgl;
    r_next.ack_s2 = r_reg.ack_s1;

    // Sequencer
    unique case (r_reg.state)
      ebl_pkg::EBL_C_START: begin
        // Waits for pin sync and link reset before the boot fetch
        r_next.wait_cnt = r_reg.wait_cnt + 5'h01;
        if (r_reg.wait_cnt == `EBL_BOOT_WAIT) begin
          if (!r_reg.pres_s2) begin
            r_next.cfg = `EBL_DEF_CFG;
            r_next.base = `EBL_DEF_BASE;
            r_next.sta0 = `EBL_DEF_STA0;
            r_next.sta1 = `EBL_DEF_STA1;
            r_next.sta2 = `EBL_DEF_STA2;
            r_next.state = ebl_pkg::EBL_C_IDLE;
          end else begin
            r_next.mode = ebl_pkg::EBL_M_LOAD;
            r_next.step = 3'h0;
            r_next.state = ebl_pkg::EBL_C_ISSUE;
          end
        end
      end
      ebl_pkg::EBL_C_IDLE: begin
      end
      ebl_pkg::EBL_C_ISSUE: begin
        // Command is held stable until the link answers
        r_next.cmd = op_for(r_reg);
        r_next.req_tgl = !r_reg.req_tgl;
        r_next.state = ebl_pkg::EBL_C_WAIT;
      end
      ebl_pkg::EBL_C_WAIT: begin
        if (r_reg.ack_s2 != r_reg.ack_seen) begin
          r_next.ack_seen = r_reg.ack_s2;
          if (r_reg.mode == ebl_pkg::EBL_M_GP_RD) begin
            r_next.gp = l_reg.rdata;
          end else if (r_reg.mode == ebl_pkg::EBL_M_LOAD) begin
            unique case (r_reg.step)
              3'h0: r_next.sta0 = l_reg.rdata;
              3'h1: r_next.sta1 = l_reg.rdata;
              3'h2: r_next.sta2 = l_reg.rdata;
              3'h3: r_next.cfg = l_reg.rdata;
              default: r_next.base = l_reg.rdata;
            endcase
          end
          if (r_reg.step == last_step(r_reg)) begin
            // Slot 7 keeps fixed values so a blank EEPROM still boots
            if (r_reg.mode == ebl_pkg::EBL_M_LOAD && r_reg.slot_s2 == `EBL_SLOT_DEFAULT) begin
              r_next.cfg = `EBL_DEF_CFG;
              r_next.base = `EBL_DEF_BASE;
            end
            r_next.state = ebl_pkg::EBL_C_IDLE;
          end else begin
            r_next.step = r_reg.step + 3'h1;
            r_next.state = ebl_pkg::EBL_C_ISSUE;
          end
        end
      end
    endcase

    // Write channel capture, either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = s_axi_awaddr_i[7:0];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      r_next.w_full = 1'b1;
      r_next.w_data = s_axi_wdata_i;
      r_next.w_strb = s_axi_wstrb_i;
    end
    if (r_reg.bvalid && s_axi_bready_i) begin
      r_next.bvalid = 1'b0;
    end

    // Write execution
    if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
      r_next.aw_full = 1'b0;
      r_next.w_full = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `EBL_RESP_OKAY;
      if (busy && waddr != `EBL_OFF_CTRL) begin
        r_next.bresp = `EBL_RESP_SLVERR;
      end else begin
        unique case (waddr)
          `EBL_OFF_CTRL: begin
            // Ignored while busy; reload wins if both set
            if (!busy && r_reg.w_strb[0]) begin
              r_next.sel = r_reg.w_data[`EBL_CTRL_SELECT];
              r_next.step = 3'h0;
              if (r_reg.w_data[`EBL_CTRL_RELOAD]) begin
                r_next.mode = r_reg.w_data[`EBL_CTRL_SELECT] ? ebl_pkg::EBL_M_GP_RD : ebl_pkg::EBL_M_LOAD;
                r_next.state = r_reg.pres_s2 ? ebl_pkg::EBL_C_ISSUE : ebl_pkg::EBL_C_IDLE;
              end else if (r_reg.w_data[`EBL_CTRL_STORE]) begin
                r_next.mode = r_reg.w_data[`EBL_CTRL_SELECT] ? ebl_pkg::EBL_M_GP_WR : ebl_pkg::EBL_M_STORE;
                r_next.state = r_reg.pres_s2 ? ebl_pkg::EBL_C_ISSUE : ebl_pkg::EBL_C_IDLE;
              end
            end
          end
          `EBL_OFF_PTR: r_next.ptr = merge16(r_reg.ptr, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_GP: r_next.gp = merge16(r_reg.gp, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_CFG: r_next.cfg = merge16(r_reg.cfg, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_BASE: r_next.base = merge16(r_reg.base, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_STA0: r_next.sta0 = merge16(r_reg.sta0, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_STA1: r_next.sta1 = merge16(r_reg.sta1, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_STA2: r_next.sta2 = merge16(r_reg.sta2, r_reg.w_data, r_reg.w_strb);
          `EBL_OFF_STAT: begin
          end
          default: r_next.bresp = `EBL_RESP_DECERR;
        endcase
      end
    end

    // Read channel
    if (r_reg.rvalid && s_axi_rready_i) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `EBL_RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      if (busy && raddr != `EBL_OFF_CTRL) begin
        r_next.rresp = `EBL_RESP_SLVERR;
      end else begin
        unique case (raddr)
          `EBL_OFF_CTRL: begin
            r_next.rdata[`EBL_CTRL_SELECT] = r_reg.sel;
            r_next.rdata[`EBL_CTRL_RELOAD] = busy;
            r_next.rdata[`EBL_CTRL_STORE] = busy;
          end
          `EBL_OFF_PTR: r_next.rdata[15:0] = r_reg.ptr;
          `EBL_OFF_GP: r_next.rdata[15:0] = r_reg.gp;
          `EBL_OFF_CFG: r_next.rdata[15:0] = r_reg.cfg;
          `EBL_OFF_BASE: r_next.rdata[15:0] = r_reg.base;
          `EBL_OFF_STA0: r_next.rdata[15:0] = r_reg.sta0;
          `EBL_OFF_STA1: r_next.rdata[15:0] = r_reg.sta1;
          `EBL_OFF_STA2: r_next.rdata[15:0] = r_reg.sta2;
          `EBL_OFF_STAT: r_next.rdata[3:0] = {r_reg.pres_s2, r_reg.slot_s2};
          default: r_next.rresp = `EBL_RESP_DECERR;
        endcase
      end
    end
  end

  // Core register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
      r_reg.state <= ebl_pkg::EBL_C_START;
      r_reg.mode <= ebl_pkg::EBL_M_LOAD;
      r_reg.cmd.addr <= 6'h00;
      r_reg.cfg <= `EBL_DEF_CFG;
      r_reg.base <= `EBL_DEF_BASE;
      r_reg.sta0 <= `EBL_DEF_STA0;
      r_reg.sta1 <= `EBL_DEF_STA1;
      r_reg.sta2 <= `EBL_DEF_STA2;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: serial word engine on the link clock
  // ----------------------------------------------------------------
  assign ee_cs_o = l_reg.cs;
  assign ee_sk_o = l_reg.sk;
  assign ee_di_o = l_reg.di;

  // Link next state; reset comes through its own two-stage sync
  always_comb begin
    l_next = l_reg;
    l_next.rst_s1 = rstn_i;
    l_next.rst_s2 = l_reg.rst_s1;
    l_next.req_s1 = r_reg.req_tgl;
    l_next.req_s2 = l_reg.req_s1;
    l_next.do_s1 = ee_do_i;
    l_next.do_s2 = l_reg.do_s1;

    unique case (l_reg.state)
      ebl_pkg::EBL_L_IDLE: begin
        // Command word is stable once the toggle is seen
        if (l_reg.req_s2 != l_reg.req_seen) begin
          l_next.req_seen = l_reg.req_s2;
          l_next.cmd = r_reg.cmd;
          l_next.cs = 1'b1;
          l_next.sk = 1'b0;
          l_next.di = 1'b1;
          l_next.div = 4'h0;
          l_next.state = ebl_pkg::EBL_L_SHIFT;
          if (r_reg.cmd.wr) begin
            // Write enable always precedes a write
            l_next.shreg = {1'b1, `EBL_OP_EXT, `EBL_EWEN_ADDR, 17'h00000};
            l_next.pulses = `EBL_CMD_BITS;
            l_next.stage = 2'h0;
          end else begin
            l_next.shreg = {1'b1, `EBL_OP_READ, r_reg.cmd.addr, 17'h00000};
            l_next.pulses = `EBL_RD_BITS;
            l_next.stage = 2'h1;
          end
        end
      end
      ebl_pkg::EBL_L_SHIFT: begin
        l_next.div = l_reg.div + 4'h1;
        if (l_reg.div == `EBL_SK_HALF - 4'h1) begin
          l_next.div = 4'h0;
          if (!l_reg.sk) begin
            // Sample before each rising edge; DO sync delay fits in the low half
            l_next.sk = 1'b1;
            l_next.rx = {l_reg.rx[14:0], l_reg.do_s2};
            l_next.pulses = l_reg.pulses - 5'h01;
          end else begin
            l_next.sk = 1'b0;
            l_next.shreg = {l_reg.shreg[24:0], 1'b0};
            l_next.di = l_reg.shreg[24];
            if (l_reg.pulses == 5'h00) begin
              l_next.cs = 1'b0;
              l_next.di = 1'b0;
              l_next.state = ebl_pkg::EBL_L_GAP;
            end
          end
        end
      end
      ebl_pkg::EBL_L_GAP: begin
        l_next.div = l_reg.div + 4'h1;
        if (l_reg.div == `EBL_SK_HALF - 4'h1) begin
          l_next.div = 4'h0;
          if (l_reg.stage == 2'h0) begin
            l_next.shreg = {1'b1, `EBL_OP_WRITE, l_reg.cmd.addr, l_reg.cmd.wdata, 1'b0};
            l_next.pulses = `EBL_WR_BITS;
            l_next.stage = 2'h1;
            l_next.cs = 1'b1;
            l_next.di = 1'b1;
            l_next.state = ebl_pkg::EBL_L_SHIFT;
          end else if (l_reg.stage == 2'h1 && l_reg.cmd.wr) begin
            l_next.cs = 1'b1;
            l_next.state = ebl_pkg::EBL_L_POLL;
          end else begin
            l_next.rdata = l_reg.rx;
            l_next.ack_tgl = !l_reg.ack_tgl;
            l_next.state = ebl_pkg::EBL_L_IDLE;
          end
        end
      end
      ebl_pkg::EBL_L_POLL: begin
        // Ready status after programming; settle before trusting DO
        if (l_reg.div != `EBL_SK_HALF - 4'h1) begin
          l_next.div = l_reg.div + 4'h1;
        end else if (l_reg.do_s2) begin
          l_next.div = 4'h0;
          l_next.cs = 1'b0;
          l_next.stage = 2'h2;
          l_next.state = ebl_pkg::EBL_L_GAP;
        end
      end
    endcase

    if (!l_reg.rst_s2) begin
      l_next.req_seen = l_next.req_s2;
      l_next.ack_tgl = 1'b0;
      l_next.state = ebl_pkg::EBL_L_IDLE;
      l_next.cs = 1'b0;
      l_next.sk = 1'b0;
      l_next.di = 1'b0;
      l_next.div = 4'h0;
    end
  end

  // Link register
  always_ff @(posedge link_clk_i) begin
    l_reg <= l_next;
  end

endmodule : ebl_loader

// file: inc/ebl_cfg.svh
// Offsets, field positions, reset values and timing counts of the board setup loader
`ifndef EBL_CFG_SVH
`define EBL_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EBL_OFF_CTRL 8'h00
`define EBL_OFF_PTR 8'h04
`define EBL_OFF_GP 8'h08
`define EBL_OFF_CFG 8'h0C
`define EBL_OFF_BASE 8'h10
`define EBL_OFF_STA0 8'h14
`define EBL_OFF_STA1 8'h18
`define EBL_OFF_STA2 8'h1C
`define EBL_OFF_STAT 8'h20

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define EBL_CTRL_STORE 0
`define EBL_CTRL_RELOAD 1
`define EBL_CTRL_SELECT 2

// ----------------------------------------------------------------
// Default values (arbitrary, used without an EEPROM; CFG and BASE also used on slot 7)
// ----------------------------------------------------------------
`define EBL_DEF_CFG 16'h0000
`define EBL_DEF_BASE 16'h0000
`define EBL_DEF_STA0 16'h0000
`define EBL_DEF_STA1 16'h0000
`define EBL_DEF_STA2 16'h0000

// ----------------------------------------------------------------
// EEPROM map and serial framing
// ----------------------------------------------------------------
`define EBL_EE_STA_ADDR 6'h20
`define EBL_SLOT_DEFAULT 3'h7
`define EBL_SLOT_STRIDE_SH 2
`define EBL_OP_READ 2'h2
`define EBL_OP_WRITE 2'h1
`define EBL_OP_EXT 2'h0
`define EBL_EWEN_ADDR 6'h30
`define EBL_CMD_BITS 5'h09
`define EBL_RD_BITS 5'h1A
`define EBL_WR_BITS 5'h19

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define EBL_SK_HALF 4'h4
`define EBL_BOOT_WAIT 5'h10

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define EBL_RESP_OKAY 2'h0
`define EBL_RESP_SLVERR 2'h2
`define EBL_RESP_DECERR 2'h3

`endif

// file: inc/ebl_pkg.sv
// Types shared by the board setup loader
package ebl_pkg;

  // ----------------------------------------------------------------
  // Modes and state codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBL_M_LOAD = 2'h0,
    EBL_M_STORE = 2'h1,
    EBL_M_GP_RD = 2'h2,
    EBL_M_GP_WR = 2'h3
  } ebl_mode_t;

  typedef enum logic [3:0] {
    EBL_C_START = 4'b0001,
    EBL_C_IDLE = 4'b0010,
    EBL_C_ISSUE = 4'b0100,
    EBL_C_WAIT = 4'b1000
  } ebl_core_state_t;

  typedef enum logic [3:0] {
    EBL_L_IDLE = 4'b0001,
    EBL_L_SHIFT = 4'b0010,
    EBL_L_GAP = 4'b0100,
    EBL_L_POLL = 4'b1000
  } ebl_link_state_t;

  // ----------------------------------------------------------------
  // Word command passed across the clock crossing
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } ebl_cmd_t;

  // ----------------------------------------------------------------
  // Core domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    ebl_core_state_t state;
    ebl_mode_t mode;
    logic [2:0] step;
    logic [4:0] wait_cnt;
    logic [2:0] slot_s1;
    logic [2:0] slot_s2;
    logic pres_s1;
    logic pres_s2;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic req_tgl;
    ebl_cmd_t cmd;
    logic sel;
    logic [15:0] ptr;
    logic [15:0] gp;
    logic [15:0] cfg;
    logic [15:0] base;
    logic [15:0] sta0;
    logic [15:0] sta1;
    logic [15:0] sta2;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ebl_core_t;

  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    ebl_link_state_t state;
    ebl_cmd_t cmd;
    logic [1:0] stage;
    logic [25:0] shreg;
    logic [4:0] pulses;
    logic [3:0] div;
    logic sk;
    logic cs;
    logic di;
    logic do_s1;
    logic do_s2;
    logic [15:0] rx;
    logic [15:0] rdata;
  } ebl_link_t;

endpackage : ebl_pkg

// file: dv/ebl_loader_asserts.sv
// Port checker of the board setup loader
`timescale 1ns/1ps
module ebl_loader_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic eeprom_present_pin_i,
  input wire logic ee_cs_o,
  input wire logic ee_sk_o,
  input wire logic ee_di_o,
  input wire logic loader_busy_o
);
  // ----
  // Read request decode
  // ----
  logic ar_go;
  logic [5:0] ar_w;
  assign ar_go = s_axi_arvalid_i && s_axi_arready_o;
  assign ar_w = s_axi_araddr_i[7:2];
  // ----
  // Core side
  // ----
  property p_boot;
    @(posedge clk_i) disable iff (!rstn_i) $rose(rstn_i) && eeprom_present_pin_i |-> ##[17:80] ee_cs_o;
  endproperty
  a_boot: assert property (p_boot) else $error("no boot fetch");
  property p_absent;
    @(posedge clk_i) disable iff (!rstn_i) !eeprom_present_pin_i [*8] |-> !ee_cs_o;
  endproperty
  a_absent: assert property (p_absent) else $error("access without eeprom");
  property p_ctrl_busy;
    @(posedge clk_i) disable iff (!rstn_i) ar_go && ar_w == 6'h00 && loader_busy_o |=> s_axi_rdata_o[1:0] == 2'h3;
  endproperty
  a_ctrl_busy: assert property (p_ctrl_busy) else $error("busy bits wrong");
  property p_ctrl_idle;
    @(posedge clk_i) disable iff (!rstn_i) ar_go && ar_w == 6'h00 && !loader_busy_o |=> s_axi_rdata_o[1:0] == 2'h0;
  endproperty
  a_ctrl_idle: assert property (p_ctrl_idle) else $error("request bits not cleared");
  property p_rd_blk;
    @(posedge clk_i) disable iff (!rstn_i)
      ar_go && ar_w inside {[1:8]} && loader_busy_o |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h00000000;
  endproperty
  a_rd_blk: assert property (p_rd_blk) else $error("read not blocked");
  // ----
  // Serial link side, sampled on the link clock
  // ----
  property p_sk_idle;
    @(posedge link_clk_i) disable iff (!rstn_i) !ee_cs_o |-> !ee_sk_o;
  endproperty
  a_sk_idle: assert property (p_sk_idle) else $error("clock outside frame");
  property p_di_stable;
    @(posedge link_clk_i) disable iff (!rstn_i) $rose(ee_sk_o) |-> $stable(ee_di_o);
  endproperty
  a_di_stable: assert property (p_di_stable) else $error("data moved at clock rise");
  property p_sk_high;
    @(posedge link_clk_i) disable iff (!rstn_i) $rose(ee_sk_o) |=> ee_sk_o [*3] ##1 !ee_sk_o;
  endproperty
  a_sk_high: assert property (p_sk_high) else $error("clock high time wrong");
  c_done: cover property (@(posedge clk_i) $fell(loader_busy_o));
  c_blk: cover property (@(posedge clk_i) ar_go && loader_busy_o && ar_w != 6'h00);
  c_frame: cover property (@(posedge link_clk_i) $rose(ee_cs_o));
endmodule : ebl_loader_asserts

// file: dv/ebl_ee_model.sv
// Behavioural serial EEPROM of 64 words of 16 bits
`timescale 1ns/1ps
module ebl_ee_model #(
  parameter int BUSY = 40
) (
  input wire logic link_clk_i,
  input wire logic cs_i,
  input wire logic sk_i,
  input wire logic di_i,
  output logic do_o
);
  logic [15:0] mem [64];
  logic [25:0] sh = 26'h0000000;
  logic [7:0] op_a = 8'h00;
  logic sk_q = 1'b0;
  logic en = 1'b0;
  int n = 0;
  int bsy = 0;
  // Word i holds a pattern carrying its own address
  initial begin
    do_o = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = 16'hA500 | 16'(i);
  end
  // ----
  // Frame decode on rising serial clock
  // ----
  always @(posedge link_clk_i) begin
    sk_q <= sk_i;
    if (bsy > 0) bsy <= bsy - 1;
    if (!cs_i) begin
      n = 0;
      do_o <= ~do_o; // Released line must not look stable
    end else if (sk_i && !sk_q) begin
      sh = {sh[24:0], di_i};
      n = n + 1;
      if (n == 9) op_a = sh[7:0];
      if (n == 9 && op_a[7:4] == 4'h3) en = 1'b1;
      if (op_a[7:6] == 2'h2 && n >= 9 && n <= 25) do_o <= (n == 9) ? 1'b0 : mem[op_a[5:0]][25-n];
      if (op_a[7:6] == 2'h1 && n == 25 && en) begin
        mem[op_a[5:0]] = sh[15:0];
        bsy <= BUSY;
      end
    end else if (n == 0) do_o <= (bsy == 0); // Slow ready status
  end
endmodule : ebl_ee_model

// file: dv/testbench.sv
// Self-checking testbench of the board setup loader
`timescale 1ns/1ps
`include "ebl_cfg.svh"
module testbench;
  localparam int ADDR_W = 8;
  logic clk_i = 1'b0, rstn_i = 1'b0, link_clk_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h00000000, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic [2:0] config_slot_pins_i = 3'h3;
  logic eeprom_present_pin_i = 1'b1, ee_cs_o, ee_sk_o, ee_di_o, ee_do_i, loader_busy_o;
  logic [15:0] config_word_o, base_word_o;
  logic [47:0] station_addr_bytes_o;
  int failures = 0, compares = 0;
  // Register reads after boot on slot 3: address, data, response
  logic [41:0] rows [7] = '{{8'h0C, 32'h0000A50C, 2'h0}, {8'h10, 32'h0000A50D, 2'h0},
    {8'h14, 32'h0000A520, 2'h0}, {8'h18, 32'h0000A521, 2'h0}, {8'h1C, 32'h0000A522, 2'h0},
    {8'h20, 32'h0000000B, 2'h0}, {8'h24, 32'h00000000, 2'h3}};
  ebl_loader dut (.*);
  ebl_ee_model ee (.link_clk_i(link_clk_i), .cs_i(ee_cs_o), .sk_i(ee_sk_o), .di_i(ee_di_o), .do_o(ee_do_i));
  // ----
  // Clocks, unrelated in phase
  // ----
  initial forever #25 clk_i = ~clk_i;
  initial begin
    #13;
    forever #40 link_clk_i = ~link_clk_i;
  end
  task automatic finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rst(input logic [2:0] s, input logic p);
    rstn_i <= 1'b0;
    config_slot_pins_i <= s;
    eeprom_present_pin_i <= p;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask : rst
  // Ready sampled at negedge is the value the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
    logic ra, rw, rb;
    logic [1:0] rp;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0000, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (int k = 0; k < 99; k++) begin
      @(negedge clk_i);
      ra = s_axi_awready_o;
      rw = s_axi_wready_o;
      rb = s_axi_bvalid_o;
      rp = s_axi_bresp_o;
      @(posedge clk_i);
      if (ra) s_axi_awvalid_i <= 1'b0;
      if (rw) s_axi_wvalid_i <= 1'b0;
      if (rb) begin
        s_axi_bready_i <= 1'b0;
        chk(rp, er);
        return;
      end
    end
    failures++;
    finish_test();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rp);
    logic ra, rv;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (int k = 0; k < 99; k++) begin
      @(negedge clk_i);
      ra = s_axi_arready_o;
      rv = s_axi_rvalid_o;
      v = s_axi_rdata_o;
      rp = s_axi_rresp_o;
      @(posedge clk_i);
      if (ra) s_axi_arvalid_i <= 1'b0;
      if (rv) begin
        s_axi_rready_i <= 1'b0;
        return;
      end
    end
    failures++;
    finish_test();
  endtask : rd
  // Poll control until both request bits read low
  task automatic wt;
    logic [31:0] v;
    logic [1:0] rp;
    for (int k = 0; k < 3000; k++) begin
      rd(8'h00, v, rp);
      if (v[1:0] === 2'h0) return;
    end
    failures++;
    finish_test();
  endtask : wt
  // ----
  // Main sequence
  // ----
  initial begin
    rst(3'h3, 1'b1);
    rd(8'h0C, d, r);
    chk({d, r}, 34'h2);
    rd(8'h00, d, r);
    chk(d[1:0], 2'h3);
    wr(8'h0C, 16'h1111, 2'h2);
    wt();
    for (int i = 0; i < 7; i++) begin
      rd(rows[i][41:34], d, r);
      chk(r, rows[i][1:0]);
      if (rows[i][1:0] == 2'h0) chk(d, rows[i][33:2]);
    end
    chk(station_addr_bytes_o, 48'hA522A521A520);
    wr(8'h04, 16'h0045, 2'h0);
    wr(8'h00, 16'h0006, 2'h0);
    rd(8'h00, d, r);
    chk(d[1:0], 2'h3);
    wt();
    rd(8'h08, d, r);
    chk(d, 32'h0000A505);
    wr(8'h08, 16'h1234, 2'h0);
    wr(8'h00, 16'h0005, 2'h0);
    wt();
    chk(ee.mem[5], 16'h1234);
    wr(8'h0C, 16'hBEEF, 2'h0);
    wr(8'h00, 16'h0001, 2'h0);
    wt();
    chk({ee.mem[12], ee.mem[13]}, 32'hBEEFA50D);
    wr(8'h0C, 16'h0000, 2'h0);
    wr(8'h00, 16'h0002, 2'h0);
    wt();
    chk(config_word_o, 16'hBEEF);
    rst(3'h7, 1'b1);
    wt();
    chk({config_word_o, base_word_o}, {`EBL_DEF_CFG, `EBL_DEF_BASE});
    chk(station_addr_bytes_o, 48'hA522A521A520);
    rst(3'h3, 1'b0);
    wt();
    chk(station_addr_bytes_o, {`EBL_DEF_STA2, `EBL_DEF_STA1, `EBL_DEF_STA0});
    wr(8'h00, 16'h0002, 2'h0);
    rd(8'h00, d, r);
    chk(d[1:0], 2'h0);
    finish_test();
  end
endmodule : testbench
bind ebl_loader ebl_loader_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);
